// ### rtl/audio_ctrl_serial_port.sv
`timescale 1ns/1ps
// Purpose: Device end: decodes 16-bit commands into audio settings.
// Assumes: Bus pins are asynchronous; all sampled through two flops.
// Notes: Status inputs are active low and reported raw.
module audio_ctrl_serial_port (
    input  wire logic                    mclk_i,
    input  wire logic                    rst_i,
    three_wire_control_bus_if.dev        bus,
    input  wire logic                    status1_n_i,
    input  wire logic                    status2_n_i,
    output logic [1:0]                   input_sel_o,
    output logic                         mute_o,
    output logic                         loudness_o,
    output logic [3:0]                   bass_o,
    output logic [3:0]                   treble_o,
    output logic [5:0]                   vol_left_o,
    output logic [5:0]                   vol_right_o,
    output logic [1:0]                   mode_o
);
    logic [4:0] pin_raw;
    logic [4:0] pin_sync;
    logic       sclk_s;
    logic       frame_on;
    logic       dat_bit;
    logic [1:0] status_n;
    logic       clk_prev;
    logic       rise;
    logic       fall;
    logic       take;
    logic [3:0] bit_cnt;
    logic       frame_full;
    logic [7:0] shift;
    logic       addr_last;
    logic       value_last;
    logic       matched;
    logic [2:0] fn_latch;
    logic       fire;
    logic [7:0] value;
    logic [1:0] rd_bits;
    logic       read_sel;
    logic [5:0] vol_q [2];

    // Every pin idles high, so ones at reset give no false edge
    assign pin_raw = {status2_n_i, status1_n_i, bus.data,
                      bus.frame_select_n, bus.sclk};

    // Two flops per pin; only the second one is read onward
    for (genvar g = 0; g < 5; g++) begin : g_sync
        logic meta;
        logic held;
        always_ff @(posedge mclk_i or posedge rst_i) begin
            if (rst_i) begin
                meta <= 1'b1;
                held <= 1'b1;
            end else begin
                meta <= pin_raw[g];
                held <= meta;
            end
        end
        assign pin_sync[g] = held;
    end

    assign sclk_s   = pin_sync[0];
    assign frame_on = !pin_sync[1];
    assign dat_bit  = pin_sync[2];
    assign status_n = pin_sync[4:3];

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            clk_prev <= 1'b1;
        end else begin
            clk_prev <= sclk_s;
        end
    end

    assign rise = sclk_s && !clk_prev;
    assign fall = !sclk_s && clk_prev;
    assign take = rise && frame_on && !frame_full;

    // Frame high clears the count, so a cut frame never executes
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            bit_cnt    <= 4'h0;
            frame_full <= 1'b0;
        end else if (!frame_on) begin
            bit_cnt    <= 4'h0;
            frame_full <= 1'b0;
        end else if (take) begin
            bit_cnt <= bit_cnt + 4'h1;
            // Bits after the sixteenth are refused, not wrapped
            if (bit_cnt == 4'hF) begin
                frame_full <= 1'b1;
            end
        end
    end

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            shift <= 8'h00;
        end else if (take) begin
            shift <= {shift[6:0], dat_bit};
        end
    end

    assign addr_last  = take && bit_cnt == 4'h7;
    assign value_last = take && bit_cnt == 4'hF;
    assign value      = {shift[6:0], dat_bit};

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            matched  <= 1'b0;
            fn_latch <= 3'h0;
        end else if (!frame_on) begin
            matched <= 1'b0;
        end else if (addr_last) begin
            matched  <= shift[6:2] == tone_ctrl_pkg::ADDR_MATCH;
            fn_latch <= {shift[1:0], dat_bit};
        end
    end

    assign fire     = value_last && matched;
    assign read_sel = matched && fn_latch == tone_ctrl_pkg::FN_READ;

    // Input code 3 selects mute, so the mute flag follows the code
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            input_sel_o <= tone_ctrl_pkg::SEL_MUTE;
            mute_o      <= 1'b1;
        end else if (fire && fn_latch == tone_ctrl_pkg::FN_INPUT) begin
            input_sel_o <= value[1:0];
            mute_o      <= value[1:0] == tone_ctrl_pkg::SEL_MUTE;
        end
    end

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            loudness_o <= 1'b0;
        end else if (fire && fn_latch == tone_ctrl_pkg::FN_LOUD) begin
            loudness_o <= value[0];
        end
    end

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            bass_o <= tone_ctrl_pkg::TONE_FLAT;
        end else if (fire && fn_latch == tone_ctrl_pkg::FN_BASS) begin
            bass_o <= value[3:0];
        end
    end

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            treble_o <= tone_ctrl_pkg::TONE_FLAT;
        end else if (fire && fn_latch == tone_ctrl_pkg::FN_TREBLE) begin
            treble_o <= value[3:0];
        end
    end

    // One register per channel; balance is left to the host
    for (genvar c = 0; c < 2; c++) begin : g_vol
        localparam logic [2:0] FN_SEL = (c == 0) ?
            tone_ctrl_pkg::FN_VOL_L : tone_ctrl_pkg::FN_VOL_R;
        always_ff @(posedge mclk_i or posedge rst_i) begin
            if (rst_i) begin
                vol_q[c] <= tone_ctrl_pkg::VOL_MIN;
            end else if (fire && fn_latch == FN_SEL) begin
                vol_q[c] <= value[5:0];
            end
        end
    end
    assign vol_left_o  = vol_q[0];
    assign vol_right_o = vol_q[1];

    // Codes 000 to 011 leave the mode as it was
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            mode_o <= tone_ctrl_pkg::MODE_STEREO;
        end else if (fire && fn_latch == tone_ctrl_pkg::FN_MODE) begin
            if (value[2:1] == 2'h3) begin
                mode_o <= tone_ctrl_pkg::MODE_RIGHT;
            end else if (value[2:0] == 3'h4) begin
                mode_o <= tone_ctrl_pkg::MODE_LEFT;
            end else if (value[2:0] == 3'h5) begin
                mode_o <= tone_ctrl_pkg::MODE_STEREO;
            end
        end
    end

    // Both status bits are caught at one instant, once the address is in
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            rd_bits <= 2'h3;
        end else if (addr_last) begin
            rd_bits <= status_n;
        end
    end

    // Only ever pulls low; moves after a fall so it is settled by the rise
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            bus.data_dev_o  <= 1'b1;
            bus.data_dev_oe <= 1'b0;
        end else if (!frame_on || !read_sel || frame_full) begin
            bus.data_dev_o  <= 1'b1;
            bus.data_dev_oe <= 1'b0;
        end else if (fall && bit_cnt == 4'hE) begin
            bus.data_dev_o  <= rd_bits[1];
            bus.data_dev_oe <= !rd_bits[1];
        end else if (fall && bit_cnt == 4'hF) begin
            bus.data_dev_o  <= rd_bits[0];
            bus.data_dev_oe <= !rd_bits[0];
        end
    end
endmodule

// ### rtl/tone_ctrl_pkg.sv
// Purpose: Shared constants for the three-wire audio control bus.
// Assumes: Both ends run on a 20 MHz system clock.
// Notes: Contract list below.
// Contract
// - Data sampled on bus clock rising edge
// - Two active-low status inputs sent back
// - Address byte while frame low, 40h-47h
// - Command is address byte then value
// - Value latched into selected setting
// - Controller drives data open-drain only
// - Controller bus clock at most 1 MHz
// - Reset: min volume, flat tone, mute
// - Separate left and right volume settings
// - Three lines, address first, serial
// - Function addresses 40h-47h in order
// - Input select 00..11, 11 is mute
// - Mode 100 left, 101 stereo, 11x right
// - Readback bit0 status1, bit1 status2
package tone_ctrl_pkg;
    localparam logic [7:0] ADDR_BASE   = 8'h40;
    localparam logic [4:0] ADDR_MATCH  = 5'h08;
    localparam logic [2:0] FN_INPUT    = 3'h0;
    localparam logic [2:0] FN_LOUD     = 3'h1;
    localparam logic [2:0] FN_BASS     = 3'h2;
    localparam logic [2:0] FN_TREBLE   = 3'h3;
    localparam logic [2:0] FN_VOL_L    = 3'h4;
    localparam logic [2:0] FN_VOL_R    = 3'h5;
    localparam logic [2:0] FN_MODE     = 3'h6;
    localparam logic [2:0] FN_READ     = 3'h7;
    localparam logic [1:0] SEL_MUTE    = 2'h3;
    localparam logic [1:0] MODE_LEFT   = 2'h0;
    localparam logic [1:0] MODE_STEREO = 2'h1;
    localparam logic [1:0] MODE_RIGHT  = 2'h2;
    localparam logic [3:0] TONE_FLAT   = 4'h6;
    localparam logic [5:0] VOL_MIN     = 6'h3F;
    localparam int         SYS_HZ      = 20000000;
    localparam int         BUS_MAX_HZ  = 1000000;
    // Half period rounded up so the bus never exceeds its limit
    localparam int HALF_CYC = (SYS_HZ + 2 * BUS_MAX_HZ - 1) / (2 * BUS_MAX_HZ);
    localparam logic [3:0] HALF_CNT = 4'(HALF_CYC - 1);
endpackage

// ### rtl/three_wire_control_bus_if.sv
`timescale 1ns/1ps
interface three_wire_control_bus_if;
    logic sclk;
    logic frame_select_n;
    logic data_host_o;
    logic data_host_oe;
    logic data_dev_o;
    logic data_dev_oe;
    logic data;
    // Open-drain wire with pull-up
    assign data = !((data_host_oe && !data_host_o) ||
                    (data_dev_oe && !data_dev_o));
    modport dev  (input sclk, frame_select_n, data,
                  output data_dev_o, data_dev_oe);
    modport host (output sclk, frame_select_n, data_host_o, data_host_oe,
                  input data);
endinterface

// ### rtl/audio_ctrl_host.sv
`timescale 1ns/1ps
// Purpose: Host end: sends one 16-bit command per request.
// Assumes: Bus clock divided from mclk_i, at most 1 MHz.
// Notes: Data driven open-drain; read bits captured on rising edges.
module audio_ctrl_host (
    input  wire logic                    mclk_i,
    input  wire logic                    rst_i,
    three_wire_control_bus_if.host       bus,
    input  wire logic                    start_i,
    input  wire logic [2:0]              func_i,
    input  wire logic [7:0]              value_i,
    output logic                         busy_o,
    output logic                         done_o,
    output logic [1:0]                   status_o
);
    typedef enum logic [1:0] {
        IDLE  = 2'h0,
        SHIFT = 2'h1,
        TAIL  = 2'h3
    } state_t;
    state_t     state;
    logic [15:0] word;
    logic [3:0]  div;
    logic [4:0]  half;
    logic [1:0]  dat_sync;
    logic [1:0]  rd;

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            dat_sync <= 2'h3;
        end else begin
            dat_sync <= {dat_sync[0], bus.data};
        end
    end

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            state              <= IDLE;
            word               <= 16'h0000;
            div                <= 4'h0;
            half               <= 5'h00;
            rd                 <= 2'h3;
            bus.sclk           <= 1'b1;
            bus.frame_select_n <= 1'b1;
            bus.data_host_o    <= 1'b1;
            bus.data_host_oe   <= 1'b0;
            busy_o             <= 1'b0;
            done_o             <= 1'b0;
            status_o           <= 2'h3;
        end else begin
            done_o <= 1'b0;
            unique case (state)
                IDLE: begin
                    if (start_i) begin
                        word <= {tone_ctrl_pkg::ADDR_BASE[7:3], func_i,
                                 value_i};
                        state              <= SHIFT;
                        busy_o             <= 1'b1;
                        bus.frame_select_n <= 1'b0;
                        div                <= tone_ctrl_pkg::HALF_CNT;
                        half               <= 5'h00;
                    end
                end
                SHIFT: begin
                    if (div != 4'h0) begin
                        div <= div - 4'h1;
                    end else begin
                        div  <= tone_ctrl_pkg::HALF_CNT;
                        half <= half + 5'h01;
                        if (!half[0]) begin
                            // Low phase: set data, stable before rise
                            bus.sclk         <= 1'b0;
                            bus.data_host_o  <= word[15];
                            // Release line during readback value
                            bus.data_host_oe <= !word[15] &&
                                !(func_i == tone_ctrl_pkg::FN_READ &&
                                  half[4]);
                            word             <= {word[14:0], 1'b1};
                        end else begin
                            bus.sclk <= 1'b1;
                            if (half == 5'h1D) begin
                                rd[1] <= dat_sync[1];
                            end
                            if (half == 5'h1F) begin
                                rd[0] <= dat_sync[1];
                                state <= TAIL;
                            end
                        end
                    end
                end
                TAIL: begin
                    bus.frame_select_n <= 1'b1;
                    bus.data_host_oe   <= 1'b0;
                    bus.data_host_o    <= 1'b1;
                    busy_o             <= 1'b0;
                    done_o             <= 1'b1;
                    if (func_i == tone_ctrl_pkg::FN_READ) begin
                        status_o <= rd;
                    end
                    state <= IDLE;
                end
                default: state <= IDLE;
            endcase
        end
    end
endmodule

// ### tb/audio_ctrl_bus_asserts.sv
`timescale 1ns/1ps
// Purpose: Wire-level checks on the bus joining host and device.
// Assumes: Sampled on mclk_i; rst_i is active high.
// Notes: Both parties are design code, so every check judges them.
module audio_ctrl_bus_asserts (
    input  wire logic mclk_i,
    input  wire logic rst_i,
    input  wire logic sclk,
    input  wire logic frame_select_n,
    input  wire logic data_host_o,
    input  wire logic data_host_oe,
    input  wire logic data_dev_o,
    input  wire logic data_dev_oe,
    input  wire logic data
);
    int unsigned rises;
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (rst_i);
    // Rising bus clock edges seen inside the current frame
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            rises <= 0;
        end else if (frame_select_n) begin
            rises <= 0;
        end else if ($rose(sclk)) begin
            rises <= rises + 1;
        end
    end
    sequence s_hold_hi;
        sclk [*8];
    endsequence
    sequence s_hold_lo;
        !sclk [*8];
    endsequence
    chk_clk_high_time: assert property ($rose(sclk) |-> s_hold_hi)
        else $error("bus clock high phase too short");
    chk_clk_low_time: assert property ($fell(sclk) |-> s_hold_lo)
        else $error("bus clock low phase too short");
    chk_bit_stable: assert property (
        $rose(sclk) && !frame_select_n |-> $stable(data))
        else $error("data moved at bus clock rise");
    chk_frame_bits: assert property (
        $rose(frame_select_n) |-> rises == 16)
        else $error("frame did not carry sixteen bits");
    chk_frame_edges: assert property (
        $changed(frame_select_n) |-> sclk)
        else $error("frame select moved with bus clock low");
    chk_frame_len: assert property (
        $fell(frame_select_n) |-> ##[300:340] frame_select_n)
        else $error("frame length out of range");
    chk_addr_prefix: assert property (
        $rose(sclk) && !frame_select_n && rises < 5 |->
        data == tone_ctrl_pkg::ADDR_BASE[7 - rises])
        else $error("address prefix bit wrong");
    chk_dev_idle_free: assert property (
        frame_select_n [*4] |-> !data_dev_oe)
        else $error("device holds data outside a frame");
    chk_dev_low_late: assert property (
        !frame_select_n && data_dev_oe && !data_dev_o |-> rises >= 14)
        else $error("device pulled data low before status bits");
    chk_host_open_drain: assert property (
        data_host_oe |-> !data_host_o)
        else $error("host drove the data line high");
    chk_dev_open_drain: assert property (
        data_dev_oe |-> !data_dev_o)
        else $error("device drove the data line high");
endmodule

// ### tb/audio_ctrl_serial_port_tb_top.sv
`timescale 1ns/1ps
// Purpose: Joins host and device ends and walks every function.
// Assumes: 50 ns system clock; second bus bit-banged at 400 ns.
// Notes: Second device proves that foreign frames are ignored.
module audio_ctrl_serial_port_tb_top;
    logic       mclk_i = 1'b0;
    logic       rst_i  = 1'b1;
    logic       start  = 1'b0;
    logic [2:0] func   = 3'h0;
    logic [7:0] value  = 8'h00;
    logic       st1_n  = 1'b1;
    logic       st2_n  = 1'b1;
    logic       busy, done, mute, loud;
    logic [1:0] sel, mode, status, sel2;
    logic [3:0] bass, treble;
    logic [5:0] vl, vr;
    int         mismatches = 0;
    int         tests_run  = 0;
    three_wire_control_bus_if bus_if ();
    three_wire_control_bus_if b2 ();
    audio_ctrl_host audio_ctrl_host_i (.mclk_i(mclk_i), .rst_i(rst_i),
        .bus(bus_if), .start_i(start), .func_i(func), .value_i(value),
        .busy_o(busy), .done_o(done), .status_o(status));
    audio_ctrl_serial_port audio_ctrl_serial_port_i (.mclk_i(mclk_i),
        .rst_i(rst_i), .bus(bus_if), .status1_n_i(st1_n),
        .status2_n_i(st2_n), .input_sel_o(sel), .mute_o(mute),
        .loudness_o(loud), .bass_o(bass), .treble_o(treble),
        .vol_left_o(vl), .vol_right_o(vr), .mode_o(mode));
    audio_ctrl_serial_port foreign_audio_ctrl_serial_port_i (
        .mclk_i(mclk_i), .rst_i(rst_i), .bus(b2), .status1_n_i(1'b1),
        .status2_n_i(1'b1), .input_sel_o(sel2), .mute_o(),
        .loudness_o(), .bass_o(), .treble_o(), .vol_left_o(),
        .vol_right_o(), .mode_o());
    audio_ctrl_bus_asserts audio_ctrl_bus_asserts_i (.mclk_i(mclk_i),
        .rst_i(rst_i), .sclk(bus_if.sclk),
        .frame_select_n(bus_if.frame_select_n),
        .data_host_o(bus_if.data_host_o),
        .data_host_oe(bus_if.data_host_oe),
        .data_dev_o(bus_if.data_dev_o), .data_dev_oe(bus_if.data_dev_oe),
        .data(bus_if.data));
    always #25 mclk_i = ~mclk_i;
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic final_report();
        $display("tests_run=%0d mismatches=%0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // One host command; done is a single-cycle pulse, so poll each cycle
    task automatic send(input logic [2:0] f, input logic [7:0] v);
        int n;
        @(posedge mclk_i);
        #1;
        func = f;
        value = v;
        start = 1'b1;
        @(posedge mclk_i);
        #1;
        start = 1'b0;
        check({7'h00, busy}, 8'h01);
        n = 0;
        while (done !== 1'b1 && n < 400) begin
            @(posedge mclk_i);
            #1;
            n++;
        end
        check(8'(n < 400), 8'h01);
        check({7'h00, busy}, 8'h00);
        // Device applies the value three edges after the last bit
        repeat (3) @(posedge mclk_i);
        #1;
    endtask
    // Bench acts as a controller that may send any address byte
    task automatic bang(input logic [15:0] w);
        b2.frame_select_n = 1'b0;
        for (int i = 15; i >= 0; i--) begin
            b2.sclk = 1'b0;
            b2.data_host_oe = !w[i];
            #200;
            b2.sclk = 1'b1;
            #200;
        end
        b2.frame_select_n = 1'b1;
        b2.data_host_oe = 1'b0;
        #400;
    endtask
    // 18 host commands of about 16 us each plus two banged frames, with ample margin
    initial begin
        #1000000;
        mismatches++;
        final_report();
    end
    initial begin
        b2.sclk = 1'b1;
        b2.frame_select_n = 1'b1;
        b2.data_host_o = 1'b0;
        b2.data_host_oe = 1'b0;
        repeat (4) @(posedge mclk_i);
        #1;
        rst_i = 1'b0;
        check(8'(sel), 8'h03);
        check({7'h00, mute}, 8'h01);
        check({7'h00, loud}, 8'h00);
        check({bass, treble}, 8'h66);
        check({2'h0, vl}, 8'h3F);
        check({2'h0, vr}, 8'h3F);
        check(8'(mode), 8'h01);
        for (int k = 0; k < 4; k++) begin
            send(tone_ctrl_pkg::FN_INPUT, 8'hFC | 8'(k));
            check(8'(sel), 8'(k));
            check({7'h00, mute}, 8'(k == 3));
        end
        send(tone_ctrl_pkg::FN_LOUD, 8'h01);
        check({7'h00, loud}, 8'h01);
        send(tone_ctrl_pkg::FN_LOUD, 8'hFE);
        check({7'h00, loud}, 8'h00);
        send(tone_ctrl_pkg::FN_BASS, 8'h09);
        send(tone_ctrl_pkg::FN_TREBLE, 8'h03);
        check({bass, treble}, 8'h93);
        send(tone_ctrl_pkg::FN_VOL_L, 8'hD4);
        check({2'h0, vl}, 8'h14);
        check({2'h0, vr}, 8'h3F);
        send(tone_ctrl_pkg::FN_VOL_R, 8'h2A);
        check({2'h0, vr}, 8'h2A);
        check({2'h0, vl}, 8'h14);
        for (int k = 0; k < 4; k++) begin
            send(tone_ctrl_pkg::FN_MODE, 8'h04 + 8'(k));
            check(8'(mode), 8'(k > 1 ? 2 : k));
        end
        for (int k = 0; k < 4; k++) begin
            st1_n = k[0];
            st2_n = k[1];
            send(tone_ctrl_pkg::FN_READ, 8'hFF);
            check(8'(status), 8'(k));
        end
        check(8'(sel), 8'h03);
        bang(16'h4800);
        check(8'(sel2), 8'h03);
        bang(16'h4001);
        check(8'(sel2), 8'h01);
        final_report();
    end
endmodule
